// File: include/nsr_pkg.sv
// shared constants and types for the status register link
package nsr_pkg;
  // command opcodes
  localparam logic [7:0] OP_WR_PERMIT = 8'h06;
  localparam logic [7:0] OP_WR_FORBID = 8'h04;
  localparam logic [7:0] OP_FEAT_GET  = 8'h0f;
  localparam logic [7:0] OP_FEAT_SET  = 8'h1f;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;
  localparam logic [7:0] OP_BLK_ERASE = 8'hd8;
  localparam logic [7:0] OP_RESET     = 8'hff;
  // feature addresses
  localparam logic [7:0] FA_STATE_A   = 8'hc0;
  localparam logic [7:0] FA_STATE_B   = 8'hf0;
  localparam logic [7:0] FA_DRIVE     = 8'hd0;
  localparam logic [7:0] FA_CONFIG    = 8'hb0;
  // status byte field positions
  localparam int         ST_RUN_BIT   = 0;
  localparam int         ST_WEL_BIT   = 1;
  localparam int         ST_EFAIL_BIT = 2;
  localparam int         ST_PFAIL_BIT = 3;
  localparam int         ST_ECC_LSB   = 4;
  localparam int         CFG_ECC_BIT  = 4;
  // correction status codes
  localparam logic [3:0] ECC_CLEAN    = 4'h0;
  localparam logic [3:0] ECC_MAX_FIX  = 4'h8;
  localparam logic [3:0] ECC_UNCORR   = 4'hf;
  // reset values
  localparam logic [7:0] DRIVE_RST    = 8'h00;
  localparam logic       ECC_EN_RST   = 1'b1;
  // timing
  localparam int         CLK_NS       = 10;
  localparam int         RST_BUSY_NS  = 5000;
  localparam logic [15:0] RST_BUSY_CYC = 16'((RST_BUSY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SCLK_HALF_CYC = 4'h8;
  // host register offsets
  localparam logic [7:0] HR_CMD       = 8'h00;
  localparam logic [7:0] HR_ROW       = 8'h04;
  localparam logic [7:0] HR_STAT      = 8'h08;
  // device internal operation kinds
  typedef enum logic [2:0] {OPK_NONE, OPK_PROG, OPK_READ, OPK_ERASE, OPK_RESET} nsr_opk_t;
  // host link sequencer states
  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_END} nsr_hst_t;
endpackage : nsr_pkg

// File: include/nsr_link_if.sv
// serial link between host controller and status register device
`timescale 1ns/1ps
`default_nettype none
interface nsr_link_if;
  logic sclk;     // serial clock from host
  logic cs_n;     // frame select, active low
  logic mosi;     // host to device data
  logic miso_o;   // device data out
  logic miso_oe;  // device drives miso
  logic miso;     // resolved line, pulled high when undriven
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev  (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : nsr_link_if
`default_nettype wire

// File: rtl/nsr_dev.sv
// status register device end: feature access and flag logic
// Summary of operation
// [R1] status byte read at feature C0 or F0
// [R2] drive strength feature D0 read and write
// [R3] status readable any time, even busy
// [R4] failed program sets program-fail flag
// [R5] invalid or protected program sets program-fail
// [R6] program sequence and reset clear program-fail
// [R7] erase failure or locked erase sets erase-fail
// [R8] erase start and reset clear erase-fail
// [R9] write enable sets latch; needed before writes
// [R10] write disable clears write latch
// [R11] running bit high during internal operations
// [R12] correction field gives corrected error count
// [R13] uncorrectable errors report code 1111b
// [R14] host refreshes block on uncorrectable code; nothing here refreshes, 1111b is only reported
// [R15] correction cleared on reset, read start
// [R16] correction field meaningless with correction off
// [R17] power-on loads correction of page 0
// [R18] locked target: no busy, fail flag only
// [R19] correction enabled after power-up
// [R20] reading status changes no flag
`timescale 1ns/1ps
`default_nettype none
module nsr_dev (
  input  wire logic        pclk,
  input  wire logic        presetn,
  nsr_link_if.dev          link,
  output var  logic [23:0] op_addr,
  output var  logic        prog_start,
  output var  logic        read_start,
  output var  logic        erase_start,
  output var  logic        op_abort,
  input  wire logic        prog_done,
  input  wire logic        prog_fail,
  input  wire logic        erase_done,
  input  wire logic        erase_fail,
  input  wire logic        read_done,
  input  wire logic [3:0]  read_err_cnt,
  input  wire logic        read_uncorr,
  input  wire logic        target_locked,
  input  wire logic        target_invalid,
  output var  logic        ecc_enable,
  output var  logic [7:0]  drive_strength
);

  // whole device state
  typedef struct packed {
    logic             sclk_m, sclk_q, sclk_d; // clock sync and edge history
    logic             cs_m, cs_q, cs_d;       // select sync and edge history
    logic             mosi_m, mosi_q;         // data sync
    logic [2:0]       bitcnt;                 // bit within byte
    logic [2:0]       bytecnt;                // bytes done, saturates at 4
    logic [7:0]       shin;                   // receive shifter
    logic [7:0]       opcode;                 // first byte of frame
    logic [7:0]       faddr;                  // feature address
    logic [23:0]      addr;                   // row address bytes
    logic [7:0]       tx;                     // transmit shifter
    logic             miso_o, miso_oe;        // line drive
    logic             p_fail, e_fail, write_permit_latch, running;
    logic [3:0]       ecc;                    // correction status
    nsr_pkg::nsr_opk_t opk;                   // running operation
    logic [15:0]      rst_cnt;                // reset busy countdown
    logic             ecc_en;                 // correction enable
    logic [7:0]       drive;                  // drive strength
    logic             boot;                   // power-on read pending
    logic [23:0]      op_addr;
    logic             prog_start, read_start, erase_start, op_abort;
  } nsr_dev_st_t;

  nsr_dev_st_t st_reg;   // registered state
  nsr_dev_st_t st_next;  // next state

  // status byte as seen by the host
  function automatic logic [7:0] status_byte(input nsr_dev_st_t s);
    logic [7:0] v;
    v = 8'h00;
    v[nsr_pkg::ST_RUN_BIT]   = s.running;
    v[nsr_pkg::ST_WEL_BIT]   = s.write_permit_latch;
    v[nsr_pkg::ST_EFAIL_BIT] = s.e_fail;
    v[nsr_pkg::ST_PFAIL_BIT] = s.p_fail;
    v[nsr_pkg::ST_ECC_LSB +: 4] = s.ecc;
    return v;
  endfunction : status_byte

  // [R20] feature read mux, flags untouched
  function automatic logic [7:0] feat_read(input nsr_dev_st_t s, input logic [7:0] fa);
    logic [7:0] v;
    v = 8'h00;
    // [R1] both status addresses
    if (fa == nsr_pkg::FA_STATE_A || fa == nsr_pkg::FA_STATE_B) begin
      v = status_byte(s);
    end else if (fa == nsr_pkg::FA_DRIVE) begin
      v = s.drive;
    end else if (fa == nsr_pkg::FA_CONFIG) begin
      v[nsr_pkg::CFG_ECC_BIT] = s.ecc_en;
    end
    return v;
  endfunction : feat_read

  // next-state logic
  always_comb begin
    logic [7:0] b;
    logic       rise, fall, fend;
    b       = 8'h00;
    st_next = st_reg;
    // pins pass two flops before use
    st_next.sclk_m = link.sclk;
    st_next.sclk_q = st_reg.sclk_m;
    st_next.sclk_d = st_reg.sclk_q;
    st_next.cs_m   = link.cs_n;
    st_next.cs_q   = st_reg.cs_m;
    st_next.cs_d   = st_reg.cs_q;
    st_next.mosi_m = link.mosi;
    st_next.mosi_q = st_reg.mosi_m;
    rise = st_reg.sclk_q & ~st_reg.sclk_d;
    fall = ~st_reg.sclk_q & st_reg.sclk_d;
    fend = st_reg.cs_q & ~st_reg.cs_d;
    // start pulses last one cycle
    st_next.prog_start  = 1'b0;
    st_next.read_start  = 1'b0;
    st_next.erase_start = 1'b0;
    st_next.op_abort    = 1'b0;
    st_next.miso_oe     = ~st_reg.cs_q;
    if (st_reg.cs_q) begin
      // deselected: frame counters idle
      st_next.bitcnt  = 3'h0;
      st_next.bytecnt = 3'h0;
    end else if (rise) begin
      // sample on rising sclk
      b = {st_reg.shin[6:0], st_reg.mosi_q};
      st_next.shin   = b;
      st_next.bitcnt = st_reg.bitcnt + 3'h1;
      if (st_reg.bitcnt == 3'h7) begin
        if (st_reg.bytecnt != 3'h4) begin
          st_next.bytecnt = st_reg.bytecnt + 3'h1;
        end
        case (st_reg.bytecnt)
          3'h0: st_next.opcode = b;
          3'h1: begin
            st_next.faddr       = b;
            st_next.addr[23:16] = b;
            // [R3] status loaded whenever asked, busy or not
            if (st_reg.opcode == nsr_pkg::OP_FEAT_GET) begin
              st_next.tx = feat_read(st_reg, b);
            end
          end
          3'h2: begin
            st_next.addr[15:8] = b;
            if (st_reg.opcode == nsr_pkg::OP_FEAT_SET) begin
              // [R2] drive strength write
              if (st_reg.faddr == nsr_pkg::FA_DRIVE) begin
                st_next.drive = b;
              end else if (st_reg.faddr == nsr_pkg::FA_CONFIG) begin
                st_next.ecc_en = b[nsr_pkg::CFG_ECC_BIT];
              end
            end
          end
          3'h3: st_next.addr[7:0] = b;
          default: ;
        endcase
        // repeated reads resend the same feature
        if (st_reg.bytecnt >= 3'h2 && st_reg.opcode == nsr_pkg::OP_FEAT_GET) begin
          st_next.tx = feat_read(st_reg, st_reg.faddr);
        end
      end
    end else if (fall) begin
      // shift out on falling sclk
      st_next.miso_o = st_reg.tx[7];
      st_next.tx     = {st_reg.tx[6:0], 1'b0};
    end
    // commands execute at frame end
    if (fend && st_reg.bytecnt != 3'h0) begin
      case (st_reg.opcode)
        // [R9] write latch set
        nsr_pkg::OP_WR_PERMIT: st_next.write_permit_latch = 1'b1;
        // [R10] write latch cleared
        nsr_pkg::OP_WR_FORBID: st_next.write_permit_latch = 1'b0;
        nsr_pkg::OP_RESET: begin
          // [R6] [R8] [R15] reset clears fail flags and correction
          st_next.p_fail   = 1'b0;
          st_next.e_fail   = 1'b0;
          st_next.ecc      = nsr_pkg::ECC_CLEAN;
          // [R11] busy while reset runs
          st_next.running  = 1'b1;
          st_next.opk      = nsr_pkg::OPK_RESET;
          st_next.rst_cnt  = nsr_pkg::RST_BUSY_CYC;
          st_next.op_abort = 1'b1;
        end
        nsr_pkg::OP_PROG_EXEC: begin
          // [R9] ignored without write latch or while busy
          if (st_reg.bytecnt == 3'h4 && st_reg.write_permit_latch && !st_reg.running) begin
            // [R6] cleared by the program sequence
            st_next.p_fail  = 1'b0;
            st_next.op_addr = st_reg.addr;
            // [R5] [R18] refused target: flag only, no busy
            if (target_locked || target_invalid) begin
              st_next.p_fail = 1'b1;
            end else begin
              st_next.running    = 1'b1;
              st_next.opk        = nsr_pkg::OPK_PROG;
              st_next.prog_start = 1'b1;
            end
          end
        end
        nsr_pkg::OP_BLK_ERASE: begin
          if (st_reg.bytecnt == 3'h4 && st_reg.write_permit_latch && !st_reg.running) begin
            // [R8] cleared at erase start
            st_next.e_fail  = 1'b0;
            st_next.op_addr = st_reg.addr;
            // [R7] [R18] locked erase fails without busy
            if (target_locked) begin
              st_next.e_fail = 1'b1;
            end else begin
              st_next.running     = 1'b1;
              st_next.opk         = nsr_pkg::OPK_ERASE;
              st_next.erase_start = 1'b1;
            end
          end
        end
        nsr_pkg::OP_PAGE_READ: begin
          if (st_reg.bytecnt == 3'h4 && !st_reg.running) begin
            // [R15] correction cleared at read start
            st_next.ecc        = nsr_pkg::ECC_CLEAN;
            st_next.op_addr    = st_reg.addr;
            st_next.running    = 1'b1;
            st_next.opk        = nsr_pkg::OPK_READ;
            st_next.read_start = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // [R17] power-on read of block 0 page 0
    if (st_reg.boot) begin
      st_next.boot       = 1'b0;
      st_next.ecc        = nsr_pkg::ECC_CLEAN;
      st_next.op_addr    = 24'h000000;
      st_next.running    = 1'b1;
      st_next.opk        = nsr_pkg::OPK_READ;
      st_next.read_start = 1'b1;
    end
    // completion events come last so they win over a command in the same cycle
    if (st_reg.running) begin
      case (st_reg.opk)
        nsr_pkg::OPK_PROG: if (prog_done) begin
          st_next.running = 1'b0;
          // [R4] failed program
          if (prog_fail) begin
            st_next.p_fail = 1'b1;
          end
        end
        nsr_pkg::OPK_ERASE: if (erase_done) begin
          st_next.running = 1'b0;
          // [R7] failed erase
          if (erase_fail) begin
            st_next.e_fail = 1'b1;
          end
        end
        nsr_pkg::OPK_READ: if (read_done) begin
          st_next.running = 1'b0;
          // [R16] field left clean while correction is off
          if (st_reg.ecc_en) begin
            // [R13] uncorrectable code
            if (read_uncorr) begin
              st_next.ecc = nsr_pkg::ECC_UNCORR;
            // [R12] count saturates at the correctable maximum
            end else if (read_err_cnt > nsr_pkg::ECC_MAX_FIX) begin
              st_next.ecc = nsr_pkg::ECC_MAX_FIX;
            end else begin
              st_next.ecc = read_err_cnt;
            end
          end
        end
        nsr_pkg::OPK_RESET: begin
          // [R11] reset busy window counts down
          if (st_reg.rst_cnt <= 16'h0001) begin
            st_next.running = 1'b0;
          end else begin
            st_next.rst_cnt = st_reg.rst_cnt - 16'h0001;
          end
        end
        default: st_next.running = 1'b0;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= '0;
      st_reg.cs_m   <= 1'b1;
      st_reg.cs_q   <= 1'b1;
      st_reg.cs_d   <= 1'b1;
      // [R19] correction on after power-up
      st_reg.ecc_en <= nsr_pkg::ECC_EN_RST;
      st_reg.drive  <= nsr_pkg::DRIVE_RST;
      st_reg.boot   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flops
  assign link.miso_o    = st_reg.miso_o;
  assign link.miso_oe   = st_reg.miso_oe;
  assign op_addr        = st_reg.op_addr;
  assign prog_start     = st_reg.prog_start;
  assign read_start     = st_reg.read_start;
  assign erase_start    = st_reg.erase_start;
  assign op_abort       = st_reg.op_abort;
  assign ecc_enable     = st_reg.ecc_en;
  assign drive_strength = st_reg.drive;

endmodule : nsr_dev
`default_nettype wire

// File: rtl/nsr_host.sv
// host controller end: apb registers driving the serial feature link
`timescale 1ns/1ps
`default_nettype none
module nsr_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  nsr_link_if.host         link
);

  // whole host state
  typedef struct packed {
    logic              pready;
    logic [31:0]       prdata;
    logic [23:0]       row;      // row address for array commands
    logic [7:0]        rx;       // last byte read back
    nsr_pkg::nsr_hst_t fsm;
    logic [3:0]        div;      // half period divider
    logic [31:0]       sh;       // outgoing bits, msb first
    logic [5:0]        bits;     // bits left in frame
    logic              sclk, cs_n, mosi;
    logic              miso_m, miso_q; // line sync
  } nsr_host_st_t;

  nsr_host_st_t st_reg;   // registered state
  nsr_host_st_t st_next;  // next state

  // next-state logic
  always_comb begin
    logic       tick;
    logic [7:0] op;
    st_next        = st_reg;
    op             = pwdata[7:0];
    st_next.miso_m = link.miso;
    st_next.miso_q = st_reg.miso_m;
    // divider gives one enable per half sclk period
    tick = (st_reg.div == nsr_pkg::SCLK_HALF_CYC - 4'h1);
    st_next.div = (st_reg.fsm == nsr_pkg::HS_IDLE || tick) ? 4'h0 : st_reg.div + 4'h1;
    // apb: one wait state, pready from a flop
    st_next.pready = psel & penable & ~st_reg.pready;
    if (psel && penable && !st_reg.pready) begin
      case (paddr)
        nsr_pkg::HR_ROW:  st_next.prdata = {8'h00, st_reg.row};
        nsr_pkg::HR_STAT: st_next.prdata = {16'h0000, st_reg.rx, 7'h00,
                                            st_reg.fsm != nsr_pkg::HS_IDLE};
        default:          st_next.prdata = 32'h00000000;
      endcase
    end
    // writes take effect on the completing edge
    if (psel && penable && st_reg.pready && pwrite) begin
      if (paddr == nsr_pkg::HR_ROW) begin
        st_next.row = pwdata[23:0];
      end else if (paddr == nsr_pkg::HR_CMD && st_reg.fsm == nsr_pkg::HS_IDLE) begin
        // [R1] [R2] feature frames carry address and data byte
        if (op == nsr_pkg::OP_FEAT_GET || op == nsr_pkg::OP_FEAT_SET) begin
          st_next.sh   = {op, pwdata[15:8], pwdata[23:16], 8'h00};
          st_next.bits = 6'd24;
        end else if (op == nsr_pkg::OP_PROG_EXEC || op == nsr_pkg::OP_PAGE_READ ||
                     op == nsr_pkg::OP_BLK_ERASE) begin
          st_next.sh   = {op, st_reg.row};
          st_next.bits = 6'd32;
        end else begin
          st_next.sh   = {op, 24'h000000};
          st_next.bits = 6'd8;
        end
        st_next.cs_n = 1'b0;
        st_next.fsm  = nsr_pkg::HS_LOW;
      end
    end
    // serial frame sequencer
    case (st_reg.fsm)
      nsr_pkg::HS_IDLE: ;
      nsr_pkg::HS_LOW: begin
        st_next.mosi = st_reg.sh[31];
        if (tick) begin
          st_next.sclk = 1'b1;
          st_next.fsm  = nsr_pkg::HS_HIGH;
        end
      end
      nsr_pkg::HS_HIGH: if (tick) begin
        // miso sampled late in the high phase, long settled
        st_next.sclk = 1'b0;
        st_next.rx   = {st_reg.rx[6:0], st_reg.miso_q};
        st_next.sh   = {st_reg.sh[30:0], 1'b0};
        st_next.bits = st_reg.bits - 6'd1;
        st_next.fsm  = (st_reg.bits == 6'd1) ? nsr_pkg::HS_END : nsr_pkg::HS_LOW;
      end
      nsr_pkg::HS_END: if (tick) begin
        st_next.cs_n = 1'b1;
        st_next.fsm  = nsr_pkg::HS_IDLE;
      end
      default: st_next.fsm = nsr_pkg::HS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= '0;
      st_reg.cs_n   <= 1'b1;
      st_reg.miso_m <= 1'b1;
      st_reg.miso_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flops
  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign link.sclk = st_reg.sclk;
  assign link.cs_n = st_reg.cs_n;
  assign link.mosi = st_reg.mosi;

endmodule : nsr_host
`default_nettype wire

// File: bench/nsr_link_sva.sv
// assertions on the serial link
`timescale 1ns/1ps
`default_nettype none
module nsr_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic [5:0] bit_cnt; // clock rises in frame

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // clock rises since frame open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 6'h00;
    end else if ($fell(cs_n)) begin
      bit_cnt <= 6'h00;
    end else if ($rose(sclk)) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("clock outside frame");
  a_frame_lead: assert property ($fell(cs_n) |-> (!sclk) [*7] ##[1:2] sclk)
    else $error("late first clock");
  a_high_phase: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("bad high phase");
  a_low_phase: assert property ($fell(sclk) && !cs_n |-> (!sclk) [*8])
    else $error("short low phase");
  a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved in high");
  a_frame_length: assert property ($rose(cs_n) |->
    (bit_cnt == 6'h08 || bit_cnt == 6'h18 || bit_cnt == 6'h20))
    else $error("bad frame length");
  a_miso_hold: assert property (miso_oe && $past(miso_oe) && sclk && $past(sclk)
    |-> $stable(miso_o))
    else $error("miso moved in high");
  a_drive_in_frame: assert property ($rose(miso_oe) |-> !cs_n)
    else $error("miso driven outside frame");
  a_release_idle: assert property (cs_n [*8] |-> !miso_oe)
    else $error("miso kept after frame");

  // main frame kinds and a driven low bit
  c_short_frame: cover property ($rose(cs_n) && bit_cnt == 6'h08);
  c_feature_frame: cover property ($rose(cs_n) && bit_cnt == 6'h18);
  c_row_frame: cover property ($rose(cs_n) && bit_cnt == 6'h20);
  c_device_low: cover property (!cs_n && miso_oe && !miso);
endmodule : nsr_link_sva
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench: apb host end talking to the status device end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int     OP_WAIT = 600;     // busy time of the array stand-in
  localparam logic [19:0] ERRS = 20'h38510; // error counts fed to the reads
  logic              pclk, presetn;     // clock and active low reset
  logic              psel, penable, pwrite, pready;
  logic [7:0]        paddr;             // apb address
  logic [31:0]       pwdata, prdata, rd; // apb data, last read
  logic [23:0]       op_addr;           // row of the last array op
  logic              prog_start, read_start, erase_start, op_abort;
  logic              prog_done, erase_done, read_done;
  logic              prog_fail, erase_fail, read_uncorr;
  logic              target_locked, target_invalid, ecc_enable, abort_seen;
  logic [3:0]        read_err_cnt;      // corrected bit count for reads
  logic [7:0]        drive_strength;    // pad drive feature
  int                fail_count, n_checks;

  nsr_link_if link_bus ();
  nsr_host i_nsr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .link(link_bus));
  nsr_dev i_nsr_dev (.pclk(pclk), .presetn(presetn), .link(link_bus), .op_addr(op_addr),
    .prog_start(prog_start), .read_start(read_start), .erase_start(erase_start),
    .op_abort(op_abort), .prog_done(prog_done), .prog_fail(prog_fail),
    .erase_done(erase_done), .erase_fail(erase_fail), .read_done(read_done),
    .read_err_cnt(read_err_cnt), .read_uncorr(read_uncorr), .target_locked(target_locked),
    .target_invalid(target_invalid), .ecc_enable(ecc_enable),
    .drive_strength(drive_strength));
  nsr_link_sva i_nsr_link_sva (.pclk(pclk), .presetn(presetn), .sclk(link_bus.sclk),
    .cs_n(link_bus.cs_n), .mosi(link_bus.mosi), .miso_o(link_bus.miso_o),
    .miso_oe(link_bus.miso_oe), .miso(link_bus.miso));

  // free-running system clock
  always #5 pclk = ~pclk;

  // latch the reset command's abort pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_seen <= 1'b0;
    end else if (op_abort === 1'b1) begin
      abort_seen <= 1'b1;
    end
  end

  // array stand-in: fixed busy time per operation
  initial begin : array_model
    logic [2:0] kind;
    {prog_done, erase_done, read_done} = 3'h0;
    forever begin
      @(posedge pclk);
      kind = {prog_start, erase_start, read_start};
      if (kind != 3'h0) begin
        repeat (OP_WAIT) @(posedge pclk);
        {prog_done, erase_done, read_done} <= kind;
        @(posedge pclk);
        {prog_done, erase_done, read_done} <= 3'h0;
      end
    end
  end

  // print the counts and the verdict, then stop
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // a bounded wait ran out
  task automatic stall;
    fail_count++;
    $display("timeout at %0t", $time);
    complete_run();
  endtask : stall

  // compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) stall();
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one link command; rd ends holding the last byte shifted in
  task automatic cmd(input logic [7:0] op, input logic [7:0] fa, input logic [7:0] wd);
    int i;
    apb(nsr_pkg::HR_CMD, 1'b1, {8'h00, wd, fa, op}, rd);
    for (i = 0; i < 400; i++) begin
      apb(nsr_pkg::HR_STAT, 1'b0, 32'h0, rd);
      if (rd[0] === 1'b0) break;
    end
    if (i == 400) stall();
  endtask : cmd

  // array command carrying a row address
  task automatic row_cmd(input logic [7:0] op, input logic [23:0] row);
    apb(nsr_pkg::HR_ROW, 1'b1, {8'h00, row}, rd);
    cmd(op, 8'h00, 8'h00);
  endtask : row_cmd

  // read a feature and compare it
  task automatic getchk(input logic [7:0] fa, input logic [7:0] exp);
    cmd(nsr_pkg::OP_FEAT_GET, fa, 8'h00);
    chk(rd[15:8], exp);
  endtask : getchk

  // poll the status byte until no operation runs, then compare it
  task automatic wait_idle(input logic [7:0] exp);
    int i;
    for (i = 0; i < 20; i++) begin
      cmd(nsr_pkg::OP_FEAT_GET, nsr_pkg::FA_STATE_A, 8'h00);
      if (rd[8 + nsr_pkg::ST_RUN_BIT] === 1'b0) break;
    end
    if (i == 20) stall();
    chk(rd[15:8], exp);
  endtask : wait_idle

  // main sequence
  initial begin
    logic [3:0] e;
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    {paddr, pwdata} = 40'h0;
    {prog_fail, erase_fail, read_uncorr, target_locked, target_invalid} = 5'h00;
    read_err_cnt = 4'h3;
    fail_count = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle(8'h30);
    getchk(nsr_pkg::FA_STATE_B, 8'h30);
    chk({7'h0, ecc_enable}, 8'h1);
    getchk(nsr_pkg::FA_CONFIG, 8'h10);
    $display("test boot done");
    cmd(nsr_pkg::OP_FEAT_SET, nsr_pkg::FA_DRIVE, 8'h5a);
    getchk(nsr_pkg::FA_DRIVE, 8'h5a);
    chk(drive_strength, 8'h5a);
    $display("test drive feature done");
    row_cmd(nsr_pkg::OP_BLK_ERASE, 24'h000040);
    getchk(nsr_pkg::FA_STATE_A, 8'h30);
    cmd(nsr_pkg::OP_WR_PERMIT, 8'h00, 8'h00);
    getchk(nsr_pkg::FA_STATE_A, 8'h32);
    erase_fail <= 1'b1;
    row_cmd(nsr_pkg::OP_BLK_ERASE, 24'h000040);
    getchk(nsr_pkg::FA_STATE_A, 8'h33);
    wait_idle(8'h36);
    erase_fail <= 1'b0;
    row_cmd(nsr_pkg::OP_BLK_ERASE, 24'h000080);
    wait_idle(8'h32);
    $display("test erase done");
    prog_fail <= 1'b1;
    row_cmd(nsr_pkg::OP_PROG_EXEC, 24'h000041);
    wait_idle(8'h3a);
    prog_fail <= 1'b0;
    row_cmd(nsr_pkg::OP_PROG_EXEC, 24'h000042);
    getchk(nsr_pkg::FA_STATE_A, 8'h33);
    wait_idle(8'h32);
    target_invalid <= 1'b1;
    row_cmd(nsr_pkg::OP_PROG_EXEC, 24'h00ffff);
    getchk(nsr_pkg::FA_STATE_A, 8'h3a);
    target_invalid <= 1'b0;
    target_locked <= 1'b1;
    row_cmd(nsr_pkg::OP_BLK_ERASE, 24'h00ffc0);
    getchk(nsr_pkg::FA_STATE_A, 8'h3e);
    chk(op_addr[7:0], 8'hc0);
    target_locked <= 1'b0;
    $display("test program done");
    cmd(nsr_pkg::OP_RESET, 8'h00, 8'h00);
    getchk(nsr_pkg::FA_STATE_A, 8'h03);
    wait_idle(8'h02);
    chk({7'h0, abort_seen}, 8'h1);
    cmd(nsr_pkg::OP_WR_FORBID, 8'h00, 8'h00);
    getchk(nsr_pkg::FA_STATE_A, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      read_err_cnt <= ERRS[k*4 +: 4];
      read_uncorr <= (k == 4);
      e = (k == 4) ? nsr_pkg::ECC_UNCORR : ERRS[k*4 +: 4];
      row_cmd(nsr_pkg::OP_PAGE_READ, 24'h000100);
      getchk(nsr_pkg::FA_STATE_B, 8'h01);
      wait_idle({e, 4'h0});
    end
    $display("test correction codes done");
    cmd(nsr_pkg::OP_FEAT_SET, nsr_pkg::FA_CONFIG, 8'h00);
    chk({7'h0, ecc_enable}, 8'h0);
    read_err_cnt <= 4'h3;
    read_uncorr <= 1'b0;
    row_cmd(nsr_pkg::OP_PAGE_READ, 24'h000100);
    wait_idle(8'h00);
    $display("test correction off done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
